// >>> verilog/opmode_consts.vh
/*
 constants of the operating mode controller: mode codes, command codes,
 field positions, reset values and the restart hold time.
 assumes a 20 MHz core clock and includes by bare name.
*/
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH

`define MODE_INIT 3'h0
`define MODE_NORMAL 3'h1
`define MODE_STOP 3'h2
`define MODE_SLEEP 3'h3
`define MODE_RESTART 3'h4

// mode field of a mode command
`define CMD_NORMAL 2'h0
`define CMD_STOP 2'h1
`define CMD_SLEEP 2'h2
`define CMD_SOFT_RESET 2'h3

// write kinds; stop mode accepts all but WR_CONFIG and stop or sleep mode commands
`define WR_MODE 2'h0
`define WR_WD_REFRESH 2'h1
`define WR_STATUS_CLR 2'h2
`define WR_CONFIG 2'h3

// config word fields
`define CFG_WD_EN 0
`define CFG_HS_LSB 1
`define CFG_HS_W 4
`define CFG_BD_EN 5
`define CFG_CP_EN 6
`define CFG_CAN_LSB 7
`define CFG_CS_SRC_LSB 9
`define CFG_CS_EN 12
`define CFG_CW_TMR 13
`define CFG_CW_EN 14
`define CFG_W 15
`define CFG_RESET 15'h0001

// can states
`define CAN_OFF 2'h0
`define CAN_WAKE_CAP 2'h1
`define CAN_ON 2'h2
`define CAN_WOKEN 2'h3

// cyclic sense sources
`define CS_HS 3'h0
`define CS_WAKE 3'h1
`define CS_TMR1 3'h2
`define CS_TMR2 3'h3
`define CS_SYNC 3'h4

// restart reset pulse
`define RESTART_NS 20000
`define CLK_NS 50
`define RESTART_CYC ((`RESTART_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> verilog/config_store.v
/*
 config_store: small register holding the normal-mode configuration word.
 assumes the caller decides when a write is allowed.
*/
`timescale 1ns/1ns
`default_nettype none
module config_store #(
    parameter W = 15,
    parameter [W-1:0] RST = 15'h0001
) (
    input wire clk,
    input wire arst_n,
    input wire soft_rst,
    input wire wr_en,
    input wire [W-1:0] wr_data,
    output reg [W-1:0] rd_data
);
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= RST;
        end else if (soft_rst) begin
            rd_data <= RST;
        end else if (wr_en) begin
            rd_data <= wr_data;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/operating_mode_controller.v
/*
 operating_mode_controller: mode state machine and per-mode sub-block
 controls. assumes a decoded serial frame arrives as a one-cycle strobe
 with its write kind and payload; status bits are plain ports.
*/
`timescale 1ns/1ns
`default_nettype none
`include "opmode_consts.vh"
module operating_mode_controller #(
    parameter RESTART_CYCLES = `RESTART_CYC
) (
    input wire clk,
    input wire arst_n,
    input wire frame_valid,
    input wire frame_write,
    input wire [1:0] frame_kind,
    input wire [1:0] frame_mode,
    input wire [`CFG_W-1:0] frame_cfg,
    input wire debug_strap,
    input wire wake_event,
    input wire can_bus_wake,
    input wire brake_event,
    input wire fail_event,
    input wire park_brake_req,
    input wire ov_brake_req,
    input wire event_mask,
    input wire status_clear,
    output reg [2:0] mode_r,
    output reg spi_fail_r,
    output reg reset_out_n,
    output reg int_out_n,
    output reg main_regulator,
    output reg main_regulator_low_power,
    output reg watchdog_unit,
    output reg watchdog_long_window,
    output reg [`CFG_HS_W-1:0] high_side_switches,
    output reg bridge_drivers,
    output reg low_side_brake,
    output reg charge_pump,
    output reg [1:0] can_state,
    output reg cyclic_sense,
    output reg [2:0] cyclic_sense_src,
    output reg cyclic_wake,
    output reg cyclic_wake_timer
);
    reg [2:0] mode_nxt;
    reg debug_r;
    reg first_frame_r;
    reg can_woken_r;
    reg [15:0] rst_cnt_r;
    reg soft_rst;
    reg cfg_wr;
    reg fail_set;
    wire [`CFG_W-1:0] cfg;
    wire [1:0] can_cfg;

    config_store #(
        .W(`CFG_W),
        .RST(`CFG_RESET)
    ) u_cfg (
        .clk(clk),
        .arst_n(arst_n),
        .soft_rst(soft_rst),
        .wr_en(cfg_wr),
        .wr_data(frame_cfg),
        .rd_data(cfg)
    );

    assign can_cfg = cfg[`CFG_CAN_LSB+1:`CFG_CAN_LSB];

    function mode_cmd_ok;
        input [2:0] m;
        input [1:0] cmd;
        begin
            case (m)
                `MODE_NORMAL: mode_cmd_ok = 1'b1;
                `MODE_STOP: mode_cmd_ok = (cmd == `CMD_NORMAL) || (cmd == `CMD_SOFT_RESET);
                default: mode_cmd_ok = 1'b0;
            endcase
        end
    endfunction

    // next mode and command gating
    always @* begin
        mode_nxt = mode_r;
        soft_rst = 1'b0;
        cfg_wr = 1'b0;
        fail_set = 1'b0;
        case (mode_r)
            `MODE_INIT: begin
                // any protocol-valid frame with the reset output high leaves init, checksum ignored; a mode command other than normal sets spi fail
                if (frame_valid && reset_out_n) begin
                    mode_nxt = `MODE_NORMAL;
                    if (frame_write && frame_kind == `WR_MODE && frame_mode != `CMD_NORMAL)
                        fail_set = 1'b1;
                end
            end
            `MODE_NORMAL: begin
                if (fail_event) begin
                    mode_nxt = `MODE_RESTART;
                end else if (frame_valid && frame_write) begin
                    if (frame_kind == `WR_CONFIG) begin
                        cfg_wr = 1'b1;
                    end else if (frame_kind == `WR_MODE) begin
                        case (frame_mode)
                            `CMD_STOP: mode_nxt = `MODE_STOP;
                            `CMD_SLEEP: mode_nxt = `MODE_SLEEP;
                            `CMD_SOFT_RESET: begin
                                mode_nxt = `MODE_INIT;
                                soft_rst = 1'b1;
                            end
                            default: mode_nxt = `MODE_NORMAL;
                        endcase
                    end
                end
            end
            `MODE_STOP: begin
                // wake and brake events only reach the interrupt pin
                if (fail_event) begin
                    mode_nxt = `MODE_RESTART;
                end else if (frame_valid && frame_write) begin
                    if (frame_kind == `WR_MODE && mode_cmd_ok(mode_r, frame_mode)) begin
                        if (frame_mode == `CMD_SOFT_RESET) begin
                            mode_nxt = `MODE_INIT;
                            soft_rst = 1'b1;
                        end else begin
                            mode_nxt = `MODE_NORMAL;
                        end
                    end else if (frame_kind == `WR_CONFIG || frame_kind == `WR_MODE) begin
                        fail_set = 1'b1;
                    end
                end
            end
            `MODE_SLEEP: begin
                if (wake_event || can_bus_wake)
                    mode_nxt = `MODE_RESTART;
                else if (frame_valid && frame_write)
                    fail_set = 1'b1;
            end
            `MODE_RESTART: begin
                // transitional: leave once the reset pulse has run
                if (rst_cnt_r == RESTART_CYCLES[15:0])
                    mode_nxt = `MODE_NORMAL;
            end
            default: mode_nxt = `MODE_INIT;
        endcase
    end

    // single mode register
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= `MODE_INIT;
            reset_out_n <= 1'b0;
            rst_cnt_r <= 16'h0000;
            first_frame_r <= 1'b1;
            debug_r <= 1'b0;
            can_woken_r <= 1'b0;
            spi_fail_r <= 1'b0;
            int_out_n <= 1'b1;
        end else begin
            mode_r <= mode_nxt;
            if (mode_nxt == `MODE_RESTART && mode_r != `MODE_RESTART) begin
                rst_cnt_r <= 16'h0000;
                reset_out_n <= 1'b0;
            end else if (!reset_out_n) begin
                if (rst_cnt_r == RESTART_CYCLES[15:0])
                    reset_out_n <= 1'b1; // in init after arst_n, watchdog long window starts here
                else
                    rst_cnt_r <= rst_cnt_r + 16'h0001;
            end
            // strap caught on the first frame after reset release in init
            if (mode_r == `MODE_INIT && frame_valid && reset_out_n && first_frame_r) begin
                debug_r <= ~debug_strap;
                first_frame_r <= 1'b0;
            end
            if (mode_r == `MODE_SLEEP && can_bus_wake)
                can_woken_r <= 1'b1;
            else if (mode_r == `MODE_NORMAL)
                can_woken_r <= 1'b0;
            // set wins over clear
            if (fail_set)
                spi_fail_r <= 1'b1;
            else if (status_clear || soft_rst)
                spi_fail_r <= 1'b0; // soft reset value too
            int_out_n <= ~(mode_r == `MODE_STOP && (wake_event || brake_event) && !event_mask);
        end
    end

    // per-mode controls decoded from the mode
    always @* begin
        main_regulator = 1'b1;
        main_regulator_low_power = 1'b0;
        watchdog_unit = cfg[`CFG_WD_EN];
        watchdog_long_window = 1'b0;
        high_side_switches = cfg[`CFG_HS_LSB+`CFG_HS_W-1:`CFG_HS_LSB];
        bridge_drivers = 1'b0;
        charge_pump = 1'b0;
        low_side_brake = 1'b0;
        can_state = can_cfg;
        cyclic_sense = cfg[`CFG_CS_EN];
        cyclic_sense_src = cfg[`CFG_CS_SRC_LSB+2:`CFG_CS_SRC_LSB];
        cyclic_wake = cfg[`CFG_CW_EN];
        cyclic_wake_timer = cfg[`CFG_CW_TMR];
        case (mode_r)
            `MODE_INIT: begin
                watchdog_unit = reset_out_n;
                watchdog_long_window = 1'b1;
                high_side_switches = {`CFG_HS_W{1'b0}};
                can_state = debug_r ? `CAN_ON : `CAN_OFF;
                cyclic_sense = 1'b0;
                cyclic_wake = 1'b0;
            end
            `MODE_NORMAL: begin
                bridge_drivers = cfg[`CFG_BD_EN];
                charge_pump = cfg[`CFG_CP_EN];
            end
            `MODE_STOP: begin
                main_regulator_low_power = 1'b1;
                low_side_brake = park_brake_req || ov_brake_req;
            end
            `MODE_SLEEP: begin
                main_regulator = 1'b0;
                watchdog_unit = 1'b0;
                low_side_brake = park_brake_req || ov_brake_req;
                can_state = (can_cfg == `CAN_OFF) ? `CAN_OFF : `CAN_WAKE_CAP;
            end
            `MODE_RESTART: begin
                watchdog_unit = 1'b0;
                high_side_switches = {`CFG_HS_W{1'b0}};
                cyclic_sense = 1'b0;
                cyclic_wake = 1'b0;
                can_state = can_woken_r ? `CAN_WOKEN :
                            ((can_cfg == `CAN_OFF) ? `CAN_OFF : `CAN_WAKE_CAP);
            end
            default: main_regulator = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// >>> verification/opmode_chk.sv
/* opmode_chk: mode and per-mode control properties of the controller.
   assumes it is bound into operating_mode_controller and sees ports only. */
`timescale 1ns/1ns
`default_nettype none
`include "opmode_consts.vh"
module opmode_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic frame_valid,
    input wire logic frame_write,
    input wire logic [1:0] frame_kind,
    input wire logic [1:0] frame_mode,
    input wire logic [2:0] mode_r,
    input wire logic spi_fail_r,
    input wire logic reset_out_n,
    input wire logic main_regulator,
    input wire logic main_regulator_low_power,
    input wire logic watchdog_unit,
    input wire logic [3:0] high_side_switches,
    input wire logic bridge_drivers,
    input wire logic charge_pump,
    input wire logic [1:0] can_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // frames are dropped while the reset output is low
    wire logic fr = frame_valid && reset_out_n;
    wire logic wr = fr && frame_write;
    property p_init; mode_r == `MODE_INIT |-> main_regulator && high_side_switches == 4'h0
        && !bridge_drivers && !charge_pump; endproperty
    a_init: assert property (p_init) else $error("init controls wrong");
    property p_leave; mode_r == `MODE_INIT && fr |=> mode_r == `MODE_NORMAL; endproperty
    a_leave: assert property (p_leave) else $error("frame did not leave init");
    property p_refuse; mode_r == `MODE_STOP && wr && frame_kind == `WR_CONFIG
        |=> mode_r == `MODE_STOP && spi_fail_r; endproperty
    a_refuse: assert property (p_refuse) else $error("stop write not refused");
    property p_stop; mode_r == `MODE_STOP && $past(mode_r) == `MODE_STOP |-> !bridge_drivers
        && main_regulator_low_power && !charge_pump && $stable(high_side_switches)
        && $stable(can_state); endproperty
    a_stop: assert property (p_stop) else $error("stop settings moved");
    property p_sleep; mode_r == `MODE_SLEEP |-> !main_regulator && !watchdog_unit
        && !bridge_drivers && !charge_pump && can_state <= `CAN_WAKE_CAP; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep controls wrong");
    property p_restart; mode_r == `MODE_RESTART |-> main_regulator && !watchdog_unit
        && high_side_switches == 4'h0 && !bridge_drivers && !charge_pump; endproperty
    a_restart: assert property (p_restart) else $error("restart controls wrong");
    property p_rst_low; mode_r == `MODE_RESTART && $past(mode_r) == `MODE_RESTART
        |-> !reset_out_n; endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset output high in restart");
    property p_soft; (mode_r == `MODE_NORMAL || mode_r == `MODE_STOP) && wr
        && frame_kind == `WR_MODE && frame_mode == `CMD_SOFT_RESET |=> mode_r == `MODE_INIT;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed init");
endmodule
bind operating_mode_controller opmode_chk u_opmode_chk (.*);
`default_nettype wire

// >>> verification/mcu_model.sv
/* mcu_model: stands for the microcontroller, one decoded frame per send.
   assumes the bench calls send and judges the results itself. */
`timescale 1ns/1ns
`default_nettype none
`include "opmode_consts.vh"
module mcu_model (
    input wire logic clk,
    input wire logic reset_out_n,
    output logic frame_valid = 1'b0,
    output logic frame_write = 1'b1,
    output logic [1:0] frame_kind = 2'h0,
    output logic [1:0] frame_mode = 2'h0,
    output logic [`CFG_W-1:0] frame_cfg = 15'h0000
);
    task automatic send(input logic [1:0] k, m, input logic [14:0] c);
        int n;
        n = 0;
        @(posedge clk);
        // bounded, so a stuck reset output shows up as a failure
        while (reset_out_n !== 1'b1 && n < 900) begin
            @(posedge clk);
            n++;
        end
        frame_valid <= 1'b1;
        frame_kind <= k;
        frame_mode <= m;
        frame_cfg <= c;
        @(posedge clk);
        // released lines carry garbage, never the last frame
        frame_valid <= 1'b0;
        frame_kind <= ~k;
        frame_mode <= ~m;
        frame_cfg <= ~c;
    endtask
endmodule
`default_nettype wire

// >>> verification/operating_mode_controller_tb.sv
/* operating_mode_controller_tb: frames via mcu_model, results checked from a queue.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ns
`default_nettype none
`include "opmode_consts.vh"
module operating_mode_controller_tb;
    logic clk = 1'b0, arst_n = 1'b0, status_clear = 1'b0, wake_event = 1'b0, fv_d = 1'b0;
    logic event_mask = 1'b0, park_brake_req = 1'b0, debug_strap = 1'b1, can_bus_wake = 1'b0;
    logic brake_event = 1'b0, fail_event = 1'b0, ov_brake_req = 1'b0;
    logic [7:0] lfsr = 8'h60;
    logic [14:0] cfg = 15'h0000;
    logic [3:0] note;
    logic [3:0] exp_q[$];
    int failures = 0, comparisons = 0, cycles = 0;
    wire logic frame_valid, frame_write, spi_fail_r, reset_out_n, int_out_n, main_regulator;
    wire logic main_regulator_low_power, watchdog_unit, watchdog_long_window, bridge_drivers;
    wire logic low_side_brake, charge_pump, cyclic_sense, cyclic_wake, cyclic_wake_timer;
    wire logic [1:0] frame_kind, frame_mode, can_state;
    wire logic [2:0] mode_r, cyclic_sense_src;
    wire logic [3:0] high_side_switches;
    wire logic [14:0] frame_cfg;
    wire logic [14:0] out_word = {cyclic_wake, cyclic_wake_timer, cyclic_sense, cyclic_sense_src,
        can_state, charge_pump, bridge_drivers, high_side_switches, watchdog_unit};
    operating_mode_controller #(.RESTART_CYCLES(4)) u_operating_mode_controller (.*);
    mcu_model u_mcu_model (.*);
    always #25 clk = ~clk;
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic frame(input logic [1:0] k, m, input logic [14:0] c, input logic [3:0] e);
        exp_q.push_back(e);
        u_mcu_model.send(k, m, c);
        @(negedge clk);
    endtask
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (mode_r !== m && n < 60) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        check("mode_wait", m, mode_r);
    endtask
    always @(posedge clk) begin
        fv_d <= frame_valid;
        cycles++;
        if (cycles == 2000) begin
            failures++;
            print_verdict();
        end
    end
    always @(negedge clk) begin
        if (fv_d && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check("mode", note[3:1], mode_r);
            check("spi_fail", note[0], spi_fail_r);
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        check("rst_out_n", 1'b0, reset_out_n);
        check("init", {`MODE_INIT, 1'b1, `CAN_OFF}, {mode_r, main_regulator, can_state});
        arst_n <= 1'b1;
        frame(`WR_MODE, `CMD_SLEEP, 15'h0000, {`MODE_NORMAL, 1'b1});
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            cfg = {1'b1, i[0], 1'b1, i[2:0], (lfsr[7] && i < 4) ? `CAN_ON : `CAN_WAKE_CAP, lfsr[6:0]};
            frame(`WR_CONFIG, `CMD_NORMAL, cfg, {`MODE_NORMAL, 1'b1});
            check("cfg_out", cfg, out_word);
        end
        frame(`WR_MODE, `CMD_STOP, 15'h0000, {`MODE_STOP, 1'b1});
        check("stop", {1'b1, cfg[4:1]}, {main_regulator_low_power, out_word[4:1]});
        @(posedge clk);
        status_clear <= 1'b1;
        @(posedge clk);
        status_clear <= 1'b0;
        frame(`WR_WD_REFRESH, `CMD_NORMAL, 15'h0000, {`MODE_STOP, 1'b0});
        frame(`WR_CONFIG, `CMD_NORMAL, ~cfg, {`MODE_STOP, 1'b1});
        @(posedge clk);
        event_mask <= 1'b1;
        wake_event <= 1'b1;
        repeat (3) @(negedge clk);
        check("int_masked", 1'b1, int_out_n);
        @(posedge clk);
        event_mask <= 1'b0;
        park_brake_req <= 1'b1;
        repeat (3) @(negedge clk);
        check("int_brake", {2'h1, `MODE_STOP}, {int_out_n, low_side_brake, mode_r});
        @(posedge clk);
        wake_event <= 1'b0;
        park_brake_req <= 1'b0;
        frame(`WR_MODE, `CMD_SOFT_RESET, 15'h0000, {`MODE_INIT, 1'b0});
        frame(`WR_MODE, `CMD_NORMAL, 15'h0000, {`MODE_NORMAL, 1'b0});
        check("soft_cfg", `CFG_RESET, out_word);
        frame(`WR_CONFIG, `CMD_NORMAL, cfg, {`MODE_NORMAL, 1'b0});
        frame(`WR_MODE, `CMD_SLEEP, 15'h0000, {`MODE_SLEEP, 1'b0});
        check("sleep", {`CAN_WAKE_CAP, cfg[4:1]}, {can_state, out_word[4:1]});
        @(posedge clk);
        wake_event <= 1'b1;
        wait_mode(`MODE_RESTART);
        check("restart", 5'h00, {reset_out_n, out_word[4:1]});
        @(posedge clk);
        wake_event <= 1'b0;
        wait_mode(`MODE_NORMAL);
        check("rst_out_n", 1'b1, reset_out_n);
        @(posedge clk);
        arst_n <= 1'b0;
        debug_strap <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        frame(`WR_MODE, `CMD_NORMAL, 15'h0000, {`MODE_NORMAL, 1'b0});
        frame(`WR_MODE, `CMD_SOFT_RESET, 15'h0000, {`MODE_INIT, 1'b0});
        check("dbg_can", `CAN_ON, can_state);
        print_verdict();
    end
endmodule
`default_nettype wire
